// [hw/bfc_pkg.sv]
/*
  bfc_pkg: constants for the bit, flag and core-control execution block.
  Assumes one core clock; flag register bit order is fixed by the core.
*/
// Contract
// - bit store copies selected source bit into transfer flag, one cycle
// - bit load writes transfer flag into selected destination bit, one cycle
// - sign flag set and clear touch only that flag, one cycle
// - overflow flag set and clear touch only that flag, one cycle
// - half-carry set and clear touch only that flag, one cycle
// - interrupt on sets, off clears the interrupt-enable flag, one cycle
// - sleep takes one cycle, keeps flags, signals the sleep logic
// - watchdog restart takes one cycle, keeps flags, pulses watchdog restart
// - break signals debug and halts until debug_resume, keeps flags, no fixed cycle count
package bfc_pkg;
  // flag positions in the processor flag register
  localparam logic [2:0] BFC_FLAG_C = 3'h0;
  localparam logic [2:0] BFC_FLAG_Z = 3'h1;
  localparam logic [2:0] BFC_FLAG_N = 3'h2;
  localparam logic [2:0] BFC_FLAG_V = 3'h3;
  localparam logic [2:0] BFC_FLAG_S = 3'h4;
  localparam logic [2:0] BFC_FLAG_H = 3'h5;
  localparam logic [2:0] BFC_FLAG_T = 3'h6;
  localparam logic [2:0] BFC_FLAG_I = 3'h7;
  localparam logic [7:0] BFC_FLAGS_RESET = 8'h00;
  localparam logic [7:0] BFC_RESULT_RESET = 8'h00;
  localparam int BFC_OP_CYCLES = 1;

  // operation codes presented by the decoder
  typedef enum logic [4:0] {
    BFC_OP_NONE = 5'h00,
    BFC_OP_BIT_STORE = 5'h01,
    BFC_OP_BIT_LOAD = 5'h02,
    BFC_OP_FLAG_SET = 5'h03,
    BFC_OP_FLAG_CLEAR = 5'h04,
    BFC_OP_SWAP = 5'h05,
    BFC_OP_SLEEP = 5'h06,
    BFC_OP_WDOG = 5'h07,
    BFC_OP_BREAK = 5'h08
  } bfc_op_t;

  // execution state, one-hot
  typedef enum logic [1:0] {
    BFC_ST_RUN = 2'h1,
    BFC_ST_HALT = 2'h2
  } bfc_state_t;
endpackage

// [hw/bfc_bit_unit.sv]
/*
  bfc_bit_unit: combinational bit select, bit insert and nibble swap.
  Assumes operands are stable within the cycle they are presented.
*/
`timescale 1ns/100ps
`default_nettype none
module bfc_bit_unit #(
  parameter int WIDTH = 8
) (
  // operands
  input wire logic [WIDTH-1:0] operand,
  input wire logic [2:0] bit_sel,
  input wire logic insert_val,
  // results
  output logic picked_bit,
  output logic [WIDTH-1:0] inserted,
  output logic [WIDTH-1:0] swapped
);
  // per-bit insert of the given value at the selected position
  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi++) begin : g_ins
      assign inserted[gi] = (bit_sel == 3'(gi)) ? insert_val : operand[gi];
    end
  endgenerate

  // select and nibble exchange
  assign picked_bit = operand[bit_sel];
  assign swapped = {operand[WIDTH/2-1:0], operand[WIDTH-1:WIDTH/2]};
endmodule
`default_nettype wire

// [hw/bfc_exec.sv]
/*
  bfc_exec: executes bit transfer, flag set/clear, swap, sleep, watchdog
  restart and break. Assumes the decoder presents one op per valid pulse
  and that register-file write-back happens from result and result_we.
*/
`timescale 1ns/100ps
`default_nettype none
module bfc_exec #(
  parameter int WIDTH = 8
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // operation request
  input wire logic op_valid,
  input wire bfc_pkg::bfc_op_t op_code,
  input wire logic [2:0] bit_index,
  input wire logic [WIDTH-1:0] reg_operand,
  // debug release of break halt
  input wire logic debug_resume,
  // results
  output logic [WIDTH-1:0] result,
  output logic result_we,
  output logic [7:0] processor_flag_register,
  output logic op_done,
  // core control strobes and halt status
  output logic sleep_request,
  output logic watchdog_restart,
  output logic debug_break,
  output logic halted
);
  logic [7:0] flags_reg, flags_next;
  logic [WIDTH-1:0] result_reg, result_next;
  logic we_reg, done_reg, sleep_reg, wdog_reg, brk_reg;
  bfc_pkg::bfc_state_t state_reg, state_next;
  logic picked_bit;
  logic [WIDTH-1:0] inserted, swapped;
  logic [7:0] flag_mask;

  bfc_bit_unit #(.WIDTH(WIDTH)) bfc_bit_unit_i (
    .operand(reg_operand),
    .bit_sel(bit_index),
    .insert_val(flags_reg[bfc_pkg::BFC_FLAG_T]),
    .picked_bit(picked_bit),
    .inserted(inserted),
    .swapped(swapped)
  );

  // op decode, qualified by run state
  wire run = (state_reg == bfc_pkg::BFC_ST_RUN);
  wire go = op_valid && run;
  wire do_store = go && (op_code == bfc_pkg::BFC_OP_BIT_STORE);
  wire do_load = go && (op_code == bfc_pkg::BFC_OP_BIT_LOAD);
  wire do_set = go && (op_code == bfc_pkg::BFC_OP_FLAG_SET);
  wire do_clr = go && (op_code == bfc_pkg::BFC_OP_FLAG_CLEAR);
  wire do_swp = go && (op_code == bfc_pkg::BFC_OP_SWAP);
  wire do_slp = go && (op_code == bfc_pkg::BFC_OP_SLEEP);
  wire do_wdog = go && (op_code == bfc_pkg::BFC_OP_WDOG);
  wire do_brk = go && (op_code == bfc_pkg::BFC_OP_BREAK);
  wire known = do_store | do_load | do_set | do_clr | do_swp | do_slp | do_wdog;

  // one-bit mask from the flag index
  assign flag_mask = 8'h01 << bit_index;

  // flag update: only the addressed flag moves
  always_comb begin
    flags_next = flags_reg;
    if (do_store) begin
      flags_next[bfc_pkg::BFC_FLAG_T] = picked_bit;
    end else if (do_set) begin
      flags_next = flags_reg | flag_mask;
    end else if (do_clr) begin
      flags_next = flags_reg & ~flag_mask;
    end
  end

  // register write-back data
  always_comb begin
    result_next = result_reg;
    if (do_load) begin
      result_next = inserted;
    end else if (do_swp) begin
      result_next = swapped;
    end
  end

  // break halts until debug releases it
  always_comb begin
    case (state_reg)
      bfc_pkg::BFC_ST_RUN: state_next = do_brk ? bfc_pkg::BFC_ST_HALT : bfc_pkg::BFC_ST_RUN;
      bfc_pkg::BFC_ST_HALT: state_next = debug_resume ? bfc_pkg::BFC_ST_RUN : bfc_pkg::BFC_ST_HALT;
      default: state_next = bfc_pkg::BFC_ST_RUN;
    endcase
  end

  // state and flag storage
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      flags_reg <= bfc_pkg::BFC_FLAGS_RESET;
      result_reg <= WIDTH'(bfc_pkg::BFC_RESULT_RESET);
      state_reg <= bfc_pkg::BFC_ST_RUN;
    end else begin
      flags_reg <= flags_next;
      result_reg <= result_next;
      state_reg <= state_next;
    end
  end

  // one-cycle strobes
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      we_reg <= 1'b0;
      done_reg <= 1'b0;
      sleep_reg <= 1'b0;
      wdog_reg <= 1'b0;
      brk_reg <= 1'b0;
    end else begin
      we_reg <= do_load | do_swp;
      done_reg <= known;
      sleep_reg <= do_slp;
      wdog_reg <= do_wdog;
      brk_reg <= do_brk;
    end
  end

  // outputs
  assign result = result_reg;
  assign result_we = we_reg;
  assign processor_flag_register = flags_reg;
  assign op_done = done_reg;
  assign sleep_request = sleep_reg;
  assign watchdog_restart = wdog_reg;
  assign debug_break = brk_reg;
  assign halted = (state_reg == bfc_pkg::BFC_ST_HALT);

  // checks: bit transfer between register and transfer flag
  store_copy_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    do_store |=> processor_flag_register[bfc_pkg::BFC_FLAG_T] == $past(reg_operand[bit_index])
      && $countones(processor_flag_register ^ $past(flags_reg)) <= 1)
    else $error("bit store flag mismatch");
  load_insert_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    do_load |=> result_we && result[$past(bit_index)] == $past(flags_reg[bfc_pkg::BFC_FLAG_T])
      && $countones(result ^ $past(reg_operand)) <= 1
      && $stable(processor_flag_register))
    else $error("bit load mismatch");

  // checks: named flag set and clear move only the addressed flag
  sign_setclr_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (do_set || do_clr) && bit_index == bfc_pkg::BFC_FLAG_S
      |=> processor_flag_register[bfc_pkg::BFC_FLAG_S] == $past(do_set)
      && $countones(processor_flag_register ^ $past(flags_reg)) <= 1)
    else $error("sign flag op wrong");
  ovf_setclr_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (do_set || do_clr) && bit_index == bfc_pkg::BFC_FLAG_V
      |=> processor_flag_register[bfc_pkg::BFC_FLAG_V] == $past(do_set)
      && $countones(processor_flag_register ^ $past(flags_reg)) <= 1)
    else $error("overflow flag op wrong");
  half_setclr_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (do_set || do_clr) && bit_index == bfc_pkg::BFC_FLAG_H
      |=> processor_flag_register[bfc_pkg::BFC_FLAG_H] == $past(do_set)
      && $countones(processor_flag_register ^ $past(flags_reg)) <= 1)
    else $error("half carry op wrong");
  int_enable_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (do_set || do_clr) && bit_index == bfc_pkg::BFC_FLAG_I
      |=> processor_flag_register[bfc_pkg::BFC_FLAG_I] == $past(do_set)
      && $countones(processor_flag_register ^ $past(flags_reg)) <= 1)
    else $error("interrupt enable op wrong");
  carry_setclr_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (do_set || do_clr) && bit_index == bfc_pkg::BFC_FLAG_C
      |=> processor_flag_register[bfc_pkg::BFC_FLAG_C] == $past(do_set)
      && $countones(processor_flag_register ^ $past(flags_reg)) <= 1)
    else $error("carry flag op wrong");
  gen_set_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    do_set |=> processor_flag_register[$past(bit_index)]
      && $countones(processor_flag_register ^ $past(flags_reg)) <= 1)
    else $error("generic set wrong");
  gen_clear_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    do_clr |=> !processor_flag_register[$past(bit_index)]
      && $countones(processor_flag_register ^ $past(flags_reg)) <= 1)
    else $error("generic clear wrong");

  // checks: core control strobes last exactly one cycle
  sleep_pulse_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    do_slp |=> sleep_request && $stable(processor_flag_register))
    else $error("sleep pulse wrong");
  sleep_only_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !do_slp |=> !sleep_request)
    else $error("sleep strobe without sleep op");
  wdog_pulse_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    do_wdog |=> watchdog_restart && $stable(processor_flag_register))
    else $error("watchdog pulse wrong");
  wdog_only_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !do_wdog |=> !watchdog_restart)
    else $error("watchdog strobe without restart op");

  // checks: break halt and ignored requests
  brk_halt_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    do_brk |=> debug_break && halted && !op_done && $stable(processor_flag_register))
    else $error("break handling wrong");
  halt_ignore_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    halted && op_valid |=> !op_done && !result_we && $stable(processor_flag_register))
    else $error("op taken while halted");

  // checks: swap and write-back strobe
  swap_nib_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    do_swp |=> result_we && result == {$past(reg_operand[3:0]), $past(reg_operand[7:4])}
      && $stable(processor_flag_register))
    else $error("swap wrong");
  we_only_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !(do_load || do_swp) |=> !result_we)
    else $error("write strobe without write op");

  // checks: completion pulse one cycle after every accepted op except break
  done_pulse_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    known |=> op_done)
    else $error("op done missing");
  done_only_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !known |=> !op_done)
    else $error("op done without accepted op");

  // scenarios worth seeing
  cov_store_c: cover property (@(posedge ref_clk) do_store);
  cov_swap_c: cover property (@(posedge ref_clk) do_swp);
  cov_brk_c: cover property (@(posedge ref_clk) do_brk ##[1:20] debug_resume);
  cov_irq_on_c: cover property (@(posedge ref_clk) do_set && bit_index == bfc_pkg::BFC_FLAG_I);
  cov_sleep_c: cover property (@(posedge ref_clk) do_slp ##[1:4] do_wdog);
endmodule
`default_nettype wire

// [testbench/bfc_exec_tb.sv]
/*
  bfc_exec_tb: self-checking bench for the bit, flag and core-control block.
  Assumes the block stands alone; the bench drives every port directly.
*/
`timescale 1ns/100ps
`default_nettype none
module bfc_exec_tb;
  // stimulus and observed signals
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic op_valid = 1'b0;
  bfc_pkg::bfc_op_t op_code = bfc_pkg::BFC_OP_NONE;
  logic [2:0] bit_index = 3'h0;
  logic [7:0] reg_operand = 8'h00;
  logic debug_resume = 1'b0;
  logic [7:0] result;
  logic result_we;
  logic [7:0] processor_flag_register;
  logic op_done;
  logic sleep_request;
  logic watchdog_restart;
  logic debug_break;
  logic halted;
  logic [7:0] exp_flags = 8'h00;
  localparam logic [7:0] STORE_PAT = 8'hA5;
  int bad_count = 0;
  int check_count = 0;

  // 100 ns core clock
  always #50 ref_clk = ~ref_clk;

  bfc_exec #(.WIDTH(8)) bfc_exec_i (.ref_clk(ref_clk), .reset_n(reset_n),
    .op_valid(op_valid), .op_code(op_code), .bit_index(bit_index),
    .reg_operand(reg_operand), .debug_resume(debug_resume), .result(result),
    .result_we(result_we), .processor_flag_register(processor_flag_register),
    .op_done(op_done), .sleep_request(sleep_request),
    .watchdog_restart(watchdog_restart), .debug_break(debug_break), .halted(halted));

  // one comparison, counted
  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  // one request for one cycle, outputs sampled after the answer edge
  task automatic do_op(input bfc_pkg::bfc_op_t code, input int idx, input logic [7:0] opnd);
    @(posedge ref_clk);
    op_valid <= 1'b1;
    op_code <= code;
    bit_index <= idx[2:0];
    reg_operand <= opnd;
    @(posedge ref_clk);
    op_valid <= 1'b0;
    #1;
  endtask

  // set every flag by index, then clear every one
  task automatic flag_ops();
    for (int i = 0; i < 16; i++) begin
      do_op(i < 8 ? bfc_pkg::BFC_OP_FLAG_SET : bfc_pkg::BFC_OP_FLAG_CLEAR, i % 8, 8'h00);
      exp_flags[i % 8] = (i < 8);
      check(processor_flag_register, exp_flags, "flag op");
      check({7'h00, op_done}, 8'h01, "flag done");
    end
  endtask

  // copy each bit of a pattern into the transfer flag
  task automatic store_ops();
    for (int i = 0; i < 8; i++) begin
      do_op(bfc_pkg::BFC_OP_BIT_STORE, i, STORE_PAT);
      exp_flags[bfc_pkg::BFC_FLAG_T] = STORE_PAT[i];
      check(processor_flag_register, exp_flags, "bit store");
    end
  endtask

  // load transfer flag as one into zeros and as zero into ones
  task automatic load_ops();
    for (int i = 0; i < 8; i += 7) begin
      do_op(bfc_pkg::BFC_OP_FLAG_SET, bfc_pkg::BFC_FLAG_T, 8'h00);
      do_op(bfc_pkg::BFC_OP_BIT_LOAD, i, 8'h00);
      exp_flags[bfc_pkg::BFC_FLAG_T] = 1'b1;
      check(result, 8'h01 << i, "load one");
      check({processor_flag_register[6:0], result_we}, {exp_flags[6:0], 1'b1}, "load we");
      do_op(bfc_pkg::BFC_OP_FLAG_CLEAR, bfc_pkg::BFC_FLAG_T, 8'h00);
      do_op(bfc_pkg::BFC_OP_BIT_LOAD, i, 8'hFF);
      exp_flags[bfc_pkg::BFC_FLAG_T] = 1'b0;
      check(result, ~(8'h01 << i), "load zero");
      check(processor_flag_register, exp_flags, "load flags");
    end
  endtask

  // nibble swap, then write strobe drops
  task automatic swap_op();
    do_op(bfc_pkg::BFC_OP_SWAP, 0, 8'h3C);
    check(result, 8'hC3, "swap");
    check({processor_flag_register[6:0], result_we}, {exp_flags[6:0], 1'b1}, "swap we");
    @(posedge ref_clk);
    #1;
    check({7'h00, result_we}, 8'h00, "swap we pulse");
  endtask

  // sleep and watchdog strobes last one cycle and keep flags
  task automatic ctl_ops();
    do_op(bfc_pkg::BFC_OP_SLEEP, 0, 8'h00);
    check({4'h0, sleep_request, watchdog_restart, debug_break, op_done}, 8'h09, "sleep");
    check(processor_flag_register, exp_flags, "sleep flags");
    do_op(bfc_pkg::BFC_OP_WDOG, 0, 8'h00);
    check({4'h0, sleep_request, watchdog_restart, debug_break, op_done}, 8'h05, "wdog");
    check(processor_flag_register, exp_flags, "wdog flags");
    @(posedge ref_clk);
    #1;
    check({5'h00, sleep_request, watchdog_restart, op_done}, 8'h00, "wdog pulse");
  endtask

  // break halts, ops are ignored, resume releases
  task automatic break_op();
    do_op(bfc_pkg::BFC_OP_BREAK, 0, 8'h00);
    check({5'h00, debug_break, op_done, halted}, 8'h05, "break");
    do_op(bfc_pkg::BFC_OP_FLAG_SET, bfc_pkg::BFC_FLAG_C, 8'h00);
    check(processor_flag_register, exp_flags, "halted op flags");
    check({7'h00, op_done}, 8'h00, "halted op done");
    @(posedge ref_clk);
    debug_resume <= 1'b1;
    @(posedge ref_clk);
    debug_resume <= 1'b0;
    #1;
    check({7'h00, halted}, 8'h00, "resume");
    do_op(bfc_pkg::BFC_OP_FLAG_SET, bfc_pkg::BFC_FLAG_C, 8'h00);
    exp_flags[bfc_pkg::BFC_FLAG_C] = 1'b1;
    check(processor_flag_register, exp_flags, "after resume");
  endtask

  // empty op is refused; reset in mid-run clears a break halt
  task automatic reset_op();
    do_op(bfc_pkg::BFC_OP_NONE, 0, 8'h00);
    check({7'h00, op_done}, 8'h00, "none refused");
    check(processor_flag_register, exp_flags, "none flags");
    do_op(bfc_pkg::BFC_OP_BREAK, 0, 8'h00);
    @(posedge ref_clk);
    reset_n <= 1'b0;
    @(posedge ref_clk);
    #1;
    exp_flags = bfc_pkg::BFC_FLAGS_RESET;
    check(processor_flag_register, exp_flags, "reset flags");
    check(result, bfc_pkg::BFC_RESULT_RESET, "reset result");
    check({5'h00, result_we, op_done, halted}, 8'h00, "reset halt");
    check({5'h00, sleep_request, watchdog_restart, debug_break}, 8'h00, "reset strobes");
    @(posedge ref_clk);
    reset_n <= 1'b1;
    do_op(bfc_pkg::BFC_OP_FLAG_SET, bfc_pkg::BFC_FLAG_Z, 8'h00);
    exp_flags[bfc_pkg::BFC_FLAG_Z] = 1'b1;
    check(processor_flag_register, exp_flags, "after reset");
    check({7'h00, op_done}, 8'h01, "after reset done");
  endtask

  // verdict and end of run
  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    repeat (10) @(posedge ref_clk);
    reset_n <= 1'b1;
    flag_ops();
    store_ops();
    load_ops();
    swap_op();
    ctl_ops();
    break_op();
    reset_op();
    stop_test();
  end

  // hang guard, well beyond the roughly one hundred cycles the tests need
  initial begin
    #1000000;
    bad_count++;
    stop_test();
  end
endmodule
`default_nettype wire
